/* File: rtl/fpeg_flash_guard.sv */
// Flash program/erase guard: unlock sequencer, sector protection, option-bit
// gating and a byte-wide model of the flash array behind it.
// Assumes register file requests and memory writes arrive on i_core_clk; the
// option bits are static straps, passed through two flip-flops anyway.
//
// Operation
// - Both options zero block user writes and erases.
// - Program option one enables user programs and page erases.
// - Reset leaves controller locked.
// - Matching or debug page rewrite activates page, else lock.
// - 95H erases page only if unprotected or from debug.
// - Invalid command when unlocked relocks.
// - Mass erase only from debug port.
// - Page stays unlocked after byte writes.
// - Up to eight sectors, never below page.
// - Protect bits reset zero, user sets only.
// - Protected sectors never programmed or erased by user code.
// - 5EH maps protect register at FF9H.
// - Mass enable: anywhere; page enable: user page only, debug anywhere.
// - Programming only clears bits; erased reads FFH.
// - CPU held idle during operations.
// - Non-erase command ends programming, locks.
// - Page erase sets 512 bytes to FFH.
// - Page erase end resumes CPU, relocks.
// - Debug 63H mass erases, then relocks.
// - Status field encodes sequence and busy states.
// - Page field gives address bits 15:9.
`timescale 1ns/10ps
module fpeg_flash_guard #(
   parameter int MEM_BYTES = 8192,
   parameter int ADDR_W = 13
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // Option bits
   input wire logic i_program_write_protect_option,
   input wire logic i_secondary_write_protect_option,
   // Register file port
   input wire fpeg_pkg::fpeg_reg_req_t i_reg,
   output logic [7:0] o_reg_rdata,
   // Memory port
   input wire fpeg_pkg::fpeg_mem_req_t i_mem,
   output logic [7:0] o_mem_rdata,
   // CPU control
   output logic o_cpu_idle
);
   import fpeg_pkg::*;
   localparam int PAGES = MEM_BYTES / PAGE_BYTES;
   localparam int SECT_PAGES = (PAGES >= NUM_SECTORS) ? PAGES / NUM_SECTORS : 1;
   // ****************************************
   // Storage and state
   // ****************************************
   logic [7:0] mem_ff [MEM_BYTES];
   fpeg_state_t state_ff;
   fpeg_op_t op_ff;
   logic [7:0] page_choice_ff;
   logic [6:0] active_page_ff;
   logic [7:0] sector_write_lock_ff;
   logic sector_sel_ff;
   logic [15:0] flash_timing_khz_value_ff;
   logic [7:0] mem_rdata_ff, reg_rdata_ff;
   logic [ADDR_W-1:0] prog_addr_ff;
   logic [7:0] prog_data_ff;
   logic [1:0] fwp_sync_ff, secondary_write_protect_option_sync_ff;
   logic timer_start, timer_busy, timer_done;
   logic cmd_wr, page_wr, user_allowed, prog_ok;
   logic [7:0] flash_command_code;
   logic [5:0] flash_state_field;
   // The sector index of a page; small parts have one page per sector.
   function automatic int sector_of_page(input logic [6:0] page);
      return int'(page) / SECT_PAGES;
   endfunction
   function automatic logic sector_locked(input logic [6:0] page, input logic [7:0] lock);
      int s;
      s = sector_of_page(page);
      return (s < NUM_SECTORS) ? lock[s[2:0]] : 1'b1;
   endfunction
   // ****************************************
   // Option bit synchronisers
   // ****************************************
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         fwp_sync_ff <= 2'b00;
         secondary_write_protect_option_sync_ff <= 2'b00;
      end else begin
         fwp_sync_ff <= {fwp_sync_ff[0], i_program_write_protect_option};
         secondary_write_protect_option_sync_ff <= {secondary_write_protect_option_sync_ff[0], i_secondary_write_protect_option};
      end
   end
   // The secondary option is synchronised but never used; a clear program option
   // means the CPU is locked out and only the debugger may act.
   assign user_allowed = fwp_sync_ff[1];
   assign cmd_wr = i_reg.wr && (i_reg.addr == ADDR_FLASH_COMMAND);
   assign page_wr = i_reg.wr && (i_reg.addr == ADDR_PAGE_CHOICE);
   assign flash_command_code = i_reg.data;
   // ****************************************
   // Unlock sequencer
   // ****************************************
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_ff <= FPEG_LOCKED;
         op_ff <= FPEG_OP_PROG;
         active_page_ff <= 7'h00;
      end else begin
         case (state_ff)
            FPEG_LOCKED: begin
               if (cmd_wr && flash_command_code == CMD_UNLOCK_1) begin
                  state_ff <= FPEG_FIRST;
               end
            end
            FPEG_FIRST: begin
               if (cmd_wr) begin
                  state_ff <= (flash_command_code == CMD_UNLOCK_2) ? FPEG_SECOND : FPEG_LOCKED;
               end else if (page_wr) begin
                  state_ff <= FPEG_LOCKED;
               end
            end
            FPEG_SECOND: begin
               if (page_wr) begin
                  if (i_reg.data[6:0] == page_choice_ff[6:0] || i_reg.dbg) begin
                     state_ff <= FPEG_UNLOCKED;
                     active_page_ff <= i_reg.data[6:0];
                  end else begin
                     state_ff <= FPEG_LOCKED;
                  end
               end else if (cmd_wr) begin
                  if (i_reg.dbg && flash_command_code == CMD_MASS_ERASE) begin
                     state_ff <= FPEG_MASS_EN;
                  end else if (i_reg.dbg && flash_command_code == CMD_PAGE_ERASE) begin
                     state_ff <= FPEG_PAGE_EN;
                     active_page_ff <= page_choice_ff[6:0];
                  end else begin
                     state_ff <= FPEG_LOCKED;
                  end
               end
            end
            FPEG_UNLOCKED, FPEG_PAGE_EN, FPEG_MASS_EN: begin
               if (timer_start) begin
                  state_ff <= FPEG_BUSY;
                  op_ff <= (cmd_wr && flash_command_code == CMD_PAGE_ERASE) ? FPEG_OP_PAGE :
                           (cmd_wr ? FPEG_OP_MASS : FPEG_OP_PROG);
               end else if (cmd_wr && flash_command_code == CMD_MASS_ERASE && i_reg.dbg) begin
                  state_ff <= FPEG_MASS_EN;
               end else if (cmd_wr) begin
                  state_ff <= FPEG_LOCKED;
               end
            end
            FPEG_BUSY: begin
               if (timer_done) begin
                  // Byte programs go to the page-enabled state; erases relock.
                  state_ff <= (op_ff == FPEG_OP_PROG) ? FPEG_PAGE_EN : FPEG_LOCKED;
               end
            end
            default: state_ff <= FPEG_LOCKED;
         endcase
      end
   end
   // ****************************************
   // Operation start decisions
   // ****************************************
   always_comb begin
      prog_ok = 1'b0;
      if (i_mem.wr && (state_ff == FPEG_UNLOCKED || state_ff == FPEG_PAGE_EN || state_ff == FPEG_MASS_EN)) begin
         if (i_mem.dbg) begin
            prog_ok = 1'b1;
         end else if (user_allowed && !sector_locked(i_mem.addr[15:9], sector_write_lock_ff)) begin
            prog_ok = (state_ff == FPEG_MASS_EN) || (i_mem.addr[15:9] == active_page_ff);
         end
      end
   end
   always_comb begin
      timer_start = 1'b0;
      if (state_ff == FPEG_UNLOCKED || state_ff == FPEG_PAGE_EN || state_ff == FPEG_MASS_EN) begin
         if (cmd_wr && flash_command_code == CMD_PAGE_ERASE) begin
            timer_start = i_reg.dbg ||
                          (user_allowed && !sector_locked(active_page_ff, sector_write_lock_ff));
         end else if (cmd_wr && flash_command_code == CMD_MASS_ERASE) begin
            timer_start = i_reg.dbg && state_ff == FPEG_MASS_EN;
         end else if (!cmd_wr) begin
            timer_start = prog_ok;
         end
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         prog_addr_ff <= '0;
         prog_data_ff <= ERASED_BYTE;
      end else if (timer_start && !cmd_wr) begin
         prog_addr_ff <= i_mem.addr[ADDR_W-1:0];
         prog_data_ff <= i_mem.data;
      end
   end
   fpeg_op_timer #(.CNT_W(32)) u_timer (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_start(timer_start),
      .i_op(cmd_wr ? ((flash_command_code == CMD_PAGE_ERASE) ? FPEG_OP_PAGE : FPEG_OP_MASS) : FPEG_OP_PROG),
      .i_khz(flash_timing_khz_value_ff),
      .o_busy(timer_busy), .o_done(timer_done));
   // ****************************************
   // Flash array model
   // ****************************************
   // Commit happens at the end of the pulse so a read during it sees old data.
   always_ff @(posedge i_core_clk) begin
      if (timer_done && state_ff == FPEG_BUSY) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            if (op_ff == FPEG_OP_MASS) begin
               mem_ff[i] <= ERASED_BYTE;
            end else if (op_ff == FPEG_OP_PAGE && (i / PAGE_BYTES) == int'(active_page_ff)) begin
               mem_ff[i] <= ERASED_BYTE;
            end
         end
         if (op_ff == FPEG_OP_PROG) begin
            mem_ff[prog_addr_ff] <= mem_ff[prog_addr_ff] & prog_data_ff;
         end
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         mem_rdata_ff <= ERASED_BYTE;
      end else begin
         mem_rdata_ff <= mem_ff[i_mem.addr[ADDR_W-1:0]];
      end
   end
   // ****************************************
   // Page choice, sector lock and timing registers
   // ****************************************
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sector_sel_ff <= 1'b0;
      end else if (cmd_wr) begin
         sector_sel_ff <= (flash_command_code == CMD_SECTOR_SEL) && state_ff == FPEG_LOCKED;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         page_choice_ff <= PAGE_CHOICE_RESET;
      end else if (page_wr && !sector_sel_ff && (state_ff != FPEG_UNLOCKED || i_reg.dbg)) begin
         page_choice_ff <= i_reg.data;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sector_write_lock_ff <= SECTOR_LOCK_RESET;
      end else if (page_wr && sector_sel_ff) begin
         sector_write_lock_ff <= i_reg.dbg ? i_reg.data : (sector_write_lock_ff | i_reg.data);
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         flash_timing_khz_value_ff <= TIMING_RESET;
      end else if (i_reg.wr && i_reg.addr == ADDR_TIMING_HI) begin
         flash_timing_khz_value_ff[15:8] <= i_reg.data;
      end else if (i_reg.wr && i_reg.addr == ADDR_TIMING_LO) begin
         flash_timing_khz_value_ff[7:0] <= i_reg.data;
      end
   end
   // ****************************************
   // Status and read-back
   // ****************************************
   always_comb begin
      case (state_ff)
         FPEG_FIRST: flash_state_field = ST_FIRST;
         FPEG_SECOND: flash_state_field = ST_SECOND;
         FPEG_UNLOCKED, FPEG_PAGE_EN, FPEG_MASS_EN: flash_state_field = ST_UNLOCKED;
         FPEG_BUSY: flash_state_field = (op_ff == FPEG_OP_PROG) ? ST_PROGRAM :
                                        ((op_ff == FPEG_OP_PAGE) ? ST_PAGE_ERASE : ST_MASS_ERASE);
         default: flash_state_field = sector_sel_ff ? ST_SECTOR : ST_LOCKED;
      endcase
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         reg_rdata_ff <= 8'h00;
      end else if (i_reg.rd) begin
         case (i_reg.addr)
            ADDR_FLASH_COMMAND: reg_rdata_ff <= {2'b00, flash_state_field};
            ADDR_PAGE_CHOICE: reg_rdata_ff <= sector_sel_ff ? sector_write_lock_ff : page_choice_ff;
            ADDR_TIMING_HI: reg_rdata_ff <= flash_timing_khz_value_ff[15:8];
            ADDR_TIMING_LO: reg_rdata_ff <= flash_timing_khz_value_ff[7:0];
            default: reg_rdata_ff <= 8'h00;
         endcase
      end
   end
   assign o_reg_rdata = reg_rdata_ff;
   assign o_mem_rdata = mem_rdata_ff;
   assign o_cpu_idle = timer_busy || state_ff == FPEG_BUSY;
   // ****************************************
   // Assertions
   // ****************************************
   property p_reset_locked;
      @(posedge i_core_clk) $rose(i_rstn) |-> state_ff == FPEG_LOCKED;
   endproperty
   a_reset_locked: assert property (p_reset_locked) else $error("not locked after reset");
   property p_user_blocked;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (timer_start && !fwp_sync_ff[1]) |-> (i_reg.dbg || i_mem.dbg);
   endproperty
   a_user_blocked: assert property (p_user_blocked) else $error("user op with options clear");
   property p_lock_sticky;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (page_wr && sector_sel_ff && !i_reg.dbg) |=>
            ((sector_write_lock_ff & $past(sector_write_lock_ff)) == $past(sector_write_lock_ff));
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("protect bit cleared by user");
   property p_bad_cmd_locks;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (state_ff == FPEG_UNLOCKED && cmd_wr && flash_command_code != CMD_PAGE_ERASE
          && flash_command_code != CMD_MASS_ERASE) |=> state_ff == FPEG_LOCKED;
   endproperty
   a_bad_cmd_locks: assert property (p_bad_cmd_locks) else $error("invalid command did not relock");
   property p_mass_debug_only;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (state_ff != FPEG_BUSY ##1 state_ff == FPEG_BUSY && op_ff == FPEG_OP_MASS) |-> $past(i_reg.dbg);
   endproperty
   a_mass_debug_only: assert property (p_mass_debug_only) else $error("mass erase from user code");
   property p_busy_idle;
      @(posedge i_core_clk) disable iff (!i_rstn)
         state_ff == FPEG_BUSY |-> o_cpu_idle && flash_state_field[5:3] != 3'b000;
   endproperty
   a_busy_idle: assert property (p_busy_idle) else $error("cpu not idle while busy");
   property p_erase_relock;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (state_ff == FPEG_BUSY && op_ff != FPEG_OP_PROG && timer_done) |=> state_ff == FPEG_LOCKED;
   endproperty
   a_erase_relock: assert property (p_erase_relock) else $error("no relock after erase");
   property p_unlock_status;
      @(posedge i_core_clk) disable iff (!i_rstn)
         (state_ff == FPEG_LOCKED && cmd_wr && flash_command_code == CMD_UNLOCK_1) |=> flash_state_field == ST_FIRST;
   endproperty
   a_unlock_status: assert property (p_unlock_status) else $error("status not first unlock");

endmodule

/* File: rtl/fpeg_op_timer.sv */
// Operation timer: counts the length of a program or erase pulse from the
// kilohertz timing value and the operation kind.
// Assumes start is a single-cycle pulse from the sequencer on the same clock.
`timescale 1ns/10ps
module fpeg_op_timer #(
   parameter int CNT_W = 32
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // Control
   input wire logic i_start,
   input wire fpeg_pkg::fpeg_op_t i_op,
   input wire logic [15:0] i_khz,
   // Status
   output logic o_busy,
   output logic o_done
);
   import fpeg_pkg::*;

   logic [CNT_W-1:0] cnt_ff;
   logic busy_ff;
   logic done_ff;
   logic [CNT_W-1:0] nxt_len;

   // Cycles = time_us * kHz / 1000, at least one cycle.
   function automatic logic [CNT_W-1:0] cycles_of(input int us, input logic [15:0] khz);
      logic [47:0] prod;
      prod = 48'(us) * 48'(khz) / 48'd1000;
      if (prod == 48'd0) begin
         prod = 48'd1;
      end
      return prod[CNT_W-1:0];
   endfunction

   always_comb begin
      case (i_op)
         FPEG_OP_PROG: nxt_len = cycles_of(PROG_TIME_US, i_khz);
         FPEG_OP_PAGE: nxt_len = cycles_of(PAGE_ERASE_TIME_US, i_khz);
         default: nxt_len = cycles_of(MASS_ERASE_TIME_US, i_khz);
      endcase
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (i_start && !busy_ff) begin
            cnt_ff <= nxt_len;
            busy_ff <= 1'b1;
         end else if (busy_ff) begin
            if (cnt_ff <= CNT_W'(1)) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - CNT_W'(1);
            end
         end
      end
   end

   assign o_busy = busy_ff;
   assign o_done = done_ff;

endmodule

/* File: rtl/fpeg_pkg.sv */
// Package for the flash program/erase guard: register addresses, command codes,
// state encodings, geometry and timing constants.
// Assumes one 40 MHz core clock and an 8-bit register file port.
package fpeg_pkg;

   // ****************************************
   // Register file addresses
   // ****************************************
   localparam logic [11:0] ADDR_FLASH_COMMAND = 12'hff8;
   localparam logic [11:0] ADDR_PAGE_CHOICE = 12'hff9;
   localparam logic [11:0] ADDR_TIMING_HI = 12'hffa;
   localparam logic [11:0] ADDR_TIMING_LO = 12'hffb;

   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [7:0] CMD_UNLOCK_1 = 8'h73;
   localparam logic [7:0] CMD_UNLOCK_2 = 8'h8c;
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
   localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
   localparam logic [7:0] CMD_SECTOR_SEL = 8'h5e;

   // ****************************************
   // Reset values and geometry
   // ****************************************
   localparam logic [7:0] SECTOR_LOCK_RESET = 8'h00;
   localparam logic [7:0] PAGE_CHOICE_RESET = 8'h00;
   localparam logic [15:0] TIMING_RESET = 16'h0000;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int PAGE_LSB = 9;
   localparam int PAGE_BYTES = 512;
   localparam int NUM_SECTORS = 8;

   // ****************************************
   // Status field encodings (six bits)
   // ****************************************
   localparam logic [5:0] ST_LOCKED = 6'h00;
   localparam logic [5:0] ST_FIRST = 6'h01;
   localparam logic [5:0] ST_SECOND = 6'h02;
   localparam logic [5:0] ST_UNLOCKED = 6'h03;
   localparam logic [5:0] ST_SECTOR = 6'h04;
   localparam logic [5:0] ST_PROGRAM = 6'h08;
   localparam logic [5:0] ST_PAGE_ERASE = 6'h10;
   localparam logic [5:0] ST_MASS_ERASE = 6'h20;

   // ****************************************
   // Operation timing: microseconds per operation, scaled by kHz value
   // ****************************************
   localparam int PROG_TIME_US = 40;
   localparam int PAGE_ERASE_TIME_US = 10000;
   localparam int MASS_ERASE_TIME_US = 10000;

   typedef enum {
      FPEG_LOCKED,
      FPEG_FIRST,
      FPEG_SECOND,
      FPEG_UNLOCKED,
      FPEG_PAGE_EN,
      FPEG_MASS_EN,
      FPEG_BUSY
   } fpeg_state_t;

   typedef enum logic [1:0] {
      FPEG_OP_PROG,
      FPEG_OP_PAGE,
      FPEG_OP_MASS
   } fpeg_op_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] data;
      logic wr;
      logic rd;
      logic dbg;
   } fpeg_reg_req_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic wr;
      logic dbg;
   } fpeg_mem_req_t;

endpackage

/* File: verif/fpeg_host.sv */
// Host model: register file and memory port master standing in for CPU and debugger.
// Assumes the guard samples every request on the rising edge of i_core_clk.
`timescale 1ns/10ps
module fpeg_host (
   // Clock
   input wire logic i_core_clk,
   // Answers from the guard
   input wire logic [7:0] i_reg_rdata,
   input wire logic [7:0] i_mem_rdata,
   // Requests to the guard
   output fpeg_pkg::fpeg_reg_req_t o_reg,
   output fpeg_pkg::fpeg_mem_req_t o_mem
);
   import fpeg_pkg::*;
   initial begin
      o_reg = '0;
      o_mem = '0;
   end
   // Released lines carry the inverse of the last value, so stale data never looks fresh.
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d, input logic dbg);
      @(posedge i_core_clk);
      o_reg <= '{addr: a, data: d, wr: 1'b1, rd: 1'b0, dbg: dbg};
      @(posedge i_core_clk);
      o_reg <= '{addr: ~a, data: ~d, wr: 1'b0, rd: 1'b0, dbg: 1'b0};
   endtask
   task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
      @(posedge i_core_clk);
      o_reg <= '{addr: a, data: 8'h00, wr: 1'b0, rd: 1'b1, dbg: 1'b0};
      @(posedge i_core_clk);
      o_reg <= '{addr: ~a, data: 8'hff, wr: 1'b0, rd: 1'b0, dbg: 1'b0};
      #1 d = i_reg_rdata;
   endtask
   task automatic wr_mem(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      o_mem <= '{addr: a, data: d, wr: 1'b1, dbg: 1'b0};
      @(posedge i_core_clk);
      o_mem <= '{addr: ~a, data: ~d, wr: 1'b0, dbg: 1'b0};
   endtask
   task automatic rd_mem(input logic [15:0] a, output logic [7:0] d);
      @(posedge i_core_clk);
      o_mem <= '{addr: a, data: 8'h00, wr: 1'b0, dbg: 1'b0};
      @(posedge i_core_clk);
      #1 d = i_mem_rdata;
   endtask
endmodule

/* File: verif/tb.sv */
// Testbench for the flash guard: register sequences with expected status and array bytes.
// Assumes a timing value of 1 kHz, so programs take 1 cycle and erases 10.
`timescale 1ns/10ps
module tb;
   import fpeg_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic opt_prog = 1'b0;
   logic opt_sec = 1'b0;
   fpeg_reg_req_t reg_req;
   fpeg_mem_req_t mem_req;
   logic [7:0] reg_rdata;
   logic [7:0] mem_rdata;
   logic [7:0] v;
   logic cpu_idle;
   logic saw;
   int num_errors = 0;
   int tests_run = 0;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
   fpeg_flash_guard fpeg_flash_guard_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
      .i_program_write_protect_option(opt_prog), .i_secondary_write_protect_option(opt_sec),
      .i_reg(reg_req), .o_reg_rdata(reg_rdata), .i_mem(mem_req), .o_mem_rdata(mem_rdata), .o_cpu_idle(cpu_idle));
   fpeg_host fpeg_host_i (.i_core_clk(i_core_clk), .i_reg_rdata(reg_rdata), .i_mem_rdata(mem_rdata),
      .o_reg(reg_req), .o_mem(mem_req));
   initial begin
      forever #12.5 i_core_clk = ~i_core_clk;
   end
   task automatic tally_and_finish;
      if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c, input logic d);
      fpeg_host_i.wr_reg(ADDR_FLASH_COMMAND, c, d);
   endtask
   task automatic pg(input logic [7:0] p);
      fpeg_host_i.wr_reg(ADDR_PAGE_CHOICE, p, 1'b0);
   endtask
   task automatic st(input logic [5:0] e);
      fpeg_host_i.rd_reg(ADDR_FLASH_COMMAND, v);
      `CHK("status", {2'b00, e}, v)
   endtask
   task automatic mem(input logic [15:0] a, input logic [7:0] e);
      fpeg_host_i.rd_mem(a, v);
      `CHK("array byte", e, v)
   endtask
   task automatic unlock(input logic [7:0] p);
      pg(p);
      cmd(CMD_UNLOCK_1, 1'b0);
      cmd(CMD_UNLOCK_2, 1'b0);
      pg(p);
   endtask
   // Bounded wait for the CPU hold to rise and fall again; a hang ends the run.
   task automatic wait_op;
      saw = 1'b0;
      for (int i = 0; i < 400; i++) begin
         @(posedge i_core_clk);
         #1;
         if (cpu_idle === 1'b1) saw = 1'b1;
         else if (saw === 1'b1) return;
      end
      num_errors++;
      tally_and_finish();
   endtask
   initial begin
      repeat (3) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      st(ST_LOCKED);
      cmd(CMD_SECTOR_SEL, 1'b0);
      fpeg_host_i.rd_reg(ADDR_PAGE_CHOICE, v);
      `CHK("protect reset", SECTOR_LOCK_RESET, v)
      cmd(8'h00, 1'b0);
      fpeg_host_i.wr_reg(ADDR_TIMING_HI, 8'h00, 1'b0);
      fpeg_host_i.wr_reg(ADDR_TIMING_LO, 8'h01, 1'b0);
      cmd(CMD_UNLOCK_1, 1'b1);
      cmd(CMD_UNLOCK_2, 1'b1);
      cmd(CMD_MASS_ERASE, 1'b1);
      cmd(CMD_MASS_ERASE, 1'b1);
      st(ST_MASS_ERASE);
      wait_op();
      `CHK("cpu hold", 1'b1, saw)
      st(ST_LOCKED);
      mem(16'h1fff, ERASED_BYTE);
      unlock(8'h02);
      fpeg_host_i.wr_mem(16'h0400, 8'h00);
      repeat (4) @(posedge i_core_clk);
      mem(16'h0400, ERASED_BYTE);
      cmd(8'h00, 1'b0);
      opt_prog <= 1'b1;
      opt_sec <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      pg(8'h02);
      cmd(CMD_UNLOCK_1, 1'b0);
      st(ST_FIRST);
      cmd(CMD_UNLOCK_2, 1'b0);
      st(ST_SECOND);
      pg(8'h02);
      st(ST_UNLOCKED);
      fpeg_host_i.wr_mem(16'h0400, 8'ha5);
      wait_op();
      mem(16'h0400, 8'ha5);
      st(ST_UNLOCKED);
      fpeg_host_i.wr_mem(16'h0400, 8'h5a);
      wait_op();
      mem(16'h0400, 8'h00);
      fpeg_host_i.wr_mem(16'h0600, 8'h00);
      repeat (4) @(posedge i_core_clk);
      mem(16'h0600, ERASED_BYTE);
      cmd(CMD_PAGE_ERASE, 1'b0);
      st(ST_PAGE_ERASE);
      wait_op();
      mem(16'h0400, ERASED_BYTE);
      st(ST_LOCKED);
      pg(8'h03);
      cmd(CMD_UNLOCK_1, 1'b0);
      cmd(CMD_UNLOCK_2, 1'b0);
      pg(8'h04);
      st(ST_LOCKED);
      unlock(8'h03);
      cmd(8'h11, 1'b0);
      st(ST_LOCKED);
      unlock(8'h03);
      fpeg_host_i.wr_mem(16'h0600, 8'h0f);
      wait_op();
      cmd(CMD_MASS_ERASE, 1'b0);
      st(ST_LOCKED);
      mem(16'h0600, 8'h0f);
      cmd(8'h00, 1'b0);
      cmd(CMD_SECTOR_SEL, 1'b0);
      st(ST_SECTOR);
      pg(8'h02);
      pg(8'h00);
      fpeg_host_i.rd_reg(ADDR_PAGE_CHOICE, v);
      `CHK("protect bits", 8'h02, v)
      cmd(8'h00, 1'b0);
      fpeg_host_i.rd_reg(ADDR_PAGE_CHOICE, v);
      `CHK("page choice", 8'h03, v)
      unlock(8'h03);
      fpeg_host_i.wr_mem(16'h0600, 8'h00);
      repeat (4) @(posedge i_core_clk);
      mem(16'h0600, 8'h0f);
      cmd(CMD_PAGE_ERASE, 1'b0);
      repeat (20) @(posedge i_core_clk);
      mem(16'h0600, 8'h0f);
      fpeg_host_i.rd_reg(12'hff0, v);
      `CHK("unmapped", 8'h00, v)
      tally_and_finish();
   end
endmodule
